// [bench/bkcq_core_model.sv]
`timescale 1ns/100ps
module bkcq_core_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_go,
	input  wire logic        i_rw,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_data,
	input  wire logic [5:0]  i_xaddr,
	input  wire logic        i_page,
	output logic             o_valid,
	output logic             o_rw,
	output logic [15:0]      o_addr,
	output logic [15:0]      o_data,
	output logic [5:0]       o_xaddr,
	output logic             o_page
);
	// idle lines keep moving so a stale value never looks like a cycle
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{o_valid, o_rw, o_addr, o_data, o_xaddr, o_page} <= '0;
		end else if (i_go) begin
			{o_valid, o_rw, o_addr, o_data, o_xaddr, o_page} <= {1'b1, i_rw, i_addr, i_data, i_xaddr, i_page};
		end else begin
			o_valid <= 1'b0;
			o_rw <= ~o_rw;
			o_addr <= ~o_addr;
			o_data <= ~o_data;
			o_xaddr <= ~o_xaddr;
			o_page <= ~o_page;
		end
	end
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
	import bkcq_pkg::*;
	logic        clk, rst_n, wr_s, rd_s, go, p_rw, p_page;
	logic [7:0]  r_addr, r_wdata, rdata;
	logic [15:0] p_addr, p_data, c_addr, c_data;
	logic [5:0]  p_xaddr, c_xaddr;
	logic        c_valid, c_rw, c_page, m_a, m_b, irq, ea_q, eb_q;
	logic [7:0]  ctl, ax, ah, al, bx, bh, bl;
	logic [1:0]  mode, en, st;
	int          failures, n_tests, cycles;

	bkcq_qualifier dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_addr(r_addr), .i_reg_wdata(r_wdata),
		.i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_cpu_valid(c_valid), .i_cpu_rw(c_rw),
		.i_cpu_addr(c_addr), .i_cpu_data(c_data), .i_cpu_xaddr(c_xaddr), .i_page_sel(c_page),
		.o_match_a(m_a), .o_match_b(m_b), .o_irq(irq));
	bkcq_core_model core (.i_sys_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_rw(p_rw), .i_addr(p_addr),
		.i_data(p_data), .i_xaddr(p_xaddr), .i_page(p_page), .o_valid(c_valid), .o_rw(c_rw),
		.o_addr(c_addr), .o_data(c_data), .o_xaddr(c_xaddr), .o_page(c_page));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// address part of one comparator
	function automatic logic ahit(logic [1:0] m, logic [7:0] x, h, l, logic pg, logic [5:0] xa,
			logic [15:0] a);
		logic ex;
		ex = !pg || x[5:0] == xa;
		// full compare, 20 or 16 bits
		if (!m[0]) return pg ? ex && h[5:0] == a[13:8] && l == a[7:0] : {h, l} == a;
		if (!m[1]) return ex && (pg ? h[5:0] == a[13:8] : h == a[15:8]);
		return pg && ex;
	endfunction

	// skip reset: the time-zero clock edge would race the reset
	always @(negedge clk) begin
		if (rst_n) begin
			chk(m_a, ea_q);
			chk(m_b, eb_q);
			st = st | {eb_q, ea_q};
			if (ea_q || eb_q) chk(irq, |(st & en));
			// direction of A, data bytes from B mask in full mode
			ea_q = c_valid && mode[0] && ahit(ctl[7:6], ax, ah, al, c_page, c_xaddr, c_addr)
				&& (!ctl[3] || c_rw == ctl[2])
				&& (!mode[1] || ((ctl[5] || bh == c_data[15:8]) && (ctl[4] || bl == c_data[7:0])));
			// comparator B only in dual mode
			eb_q = c_valid && mode == 2'h1 && ahit(ctl[5:4], bx, bh, bl, c_page, c_xaddr, c_addr)
				&& (!ctl[1] || c_rw == ctl[0]);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test;
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		r_addr <= a;
		r_wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		case (a)
			OFF_CONTROL: ctl = d;
			OFF_A_EXT: ax = d;
			OFF_A_HIGH: ah = d;
			OFF_A_LOW: al = d;
			OFF_B_EXT: bx = d;
			OFF_B_HIGH: bh = d;
			OFF_B_LOW: bl = d;
			OFF_MODE: mode = d[1:0];
			OFF_IRQ_EN: en = d[1:0];
			OFF_IRQ_CLR: st = st & ~d[1:0];
			default: ;
		endcase
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge clk);
		r_addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(rdata, want);
	endtask

	// one core cycle aimed at A or B, sometimes spoiled by one flipped bit
	task automatic cyc;
		logic [7:0]  x, h, l;
		logic [15:0] a, d;
		logic [5:0]  xa;
		logic        pg;
		int          r;
		pg = 1'($urandom);
		{x, h, l} = $urandom % 2 ? {bx, bh, bl} : {ax, ah, al};
		a = pg ? {2'($urandom), h[5:0], l} : {h, l};
		xa = x[5:0];
		d = {bh, bl};
		r = $urandom % 8;
		if (r == 0) a = a ^ (16'h1 << ($urandom % 16));
		if (r == 1) xa = xa ^ (6'h1 << ($urandom % 6));
		if (r == 2) d = d ^ (16'h1 << ($urandom % 16));
		@(posedge clk);
		go <= ($urandom % 4) != 0;
		p_rw <= 1'($urandom);
		p_page <= pg;
		p_addr <= a;
		p_xaddr <= xa;
		p_data <= d;
	endtask

	initial begin
		logic [7:0] offs[11];
		offs = '{OFF_CONTROL, OFF_A_EXT, OFF_A_HIGH, OFF_A_LOW, OFF_B_EXT, OFF_B_HIGH, OFF_B_LOW,
			OFF_MODE, OFF_IRQ_ST, OFF_IRQ_EN, OFF_IRQ_CLR};
		void'($urandom(32'hd7d9d91a));
		{rst_n, wr_s, rd_s, go, p_rw, p_page, r_addr, r_wdata, p_addr, p_data, p_xaddr} = '0;
		{ctl, ax, ah, al, bx, bh, bl, mode, en, st, ea_q, eb_q} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (offs[i]) rd(offs[i], 8'h00);
		rd(8'h2c, 8'h00);
		// status is read only
		wr(OFF_IRQ_ST, 8'hff);
		rd(OFF_IRQ_ST, 8'h00);
		for (int c = 0; c < 150; c++) begin
			for (int i = 0; i < 8; i++) wr(offs[i], 8'($urandom));
			wr(OFF_IRQ_EN, 8'($urandom));
			rd(OFF_CONTROL, ctl);
			rd(OFF_B_LOW, bl);
			rd(OFF_MODE, {6'h0, mode});
			rd(OFF_IRQ_CLR, 8'h00);
			repeat (10) cyc();
			@(posedge clk);
			go <= 1'b0;
			repeat (3) @(posedge clk);
			rd(OFF_IRQ_ST, {6'h0, st});
			rd(OFF_IRQ_EN, {6'h0, en});
			wr(OFF_IRQ_CLR, 8'($urandom));
			@(negedge clk);
			chk(irq, |(st & en));
		end
		stop_test;
	end
endmodule

// [src/bkcq_addr_cmp.sv]
`timescale 1ns/100ps
module bkcq_addr_cmp (
	input  wire logic                              i_mask_high,
	input  wire logic                              i_mask_low,
	input  wire logic [bkcq_pkg::REG_W-1:0]        i_ext,
	input  wire logic [bkcq_pkg::REG_W-1:0]        i_high,
	input  wire logic [bkcq_pkg::REG_W-1:0]        i_low,
	input  wire logic                              i_page_sel,
	input  wire logic [bkcq_pkg::XADDR_W-1:0]      i_xaddr,
	input  wire logic [bkcq_pkg::CPU_W-1:0]        i_addr,
	output logic                                   o_hit
);
	import bkcq_pkg::*;

	logic ext_ok;
	logic high_ok;
	logic low_ok;

	always_comb begin
		ext_ok = !i_page_sel || (i_xaddr == i_ext[XADDR_W-1:0]);
		if (i_page_sel) begin
			high_ok = i_high[XADDR_W-1:0] == i_addr[BYTE_W+XADDR_W-1:BYTE_W];
		end else begin
			high_ok = i_high == i_addr[CPU_W-1:BYTE_W];
		end
		low_ok = i_low == i_addr[BYTE_W-1:0];
		if (i_mask_high && i_mask_low) begin
			o_hit = i_page_sel && ext_ok;
		end else if (i_mask_low) begin
			o_hit = ext_ok && high_ok;
		end else begin
			o_hit = ext_ok && high_ok && low_ok;
		end
	end
endmodule

// [src/bkcq_data_cmp.sv]
`timescale 1ns/100ps
module bkcq_data_cmp (
	input  wire logic                          i_mask_high,
	input  wire logic                          i_mask_low,
	input  wire logic [bkcq_pkg::REG_W-1:0]    i_high,
	input  wire logic [bkcq_pkg::REG_W-1:0]    i_low,
	input  wire logic [bkcq_pkg::CPU_W-1:0]    i_data,
	output logic                               o_hit
);
	import bkcq_pkg::*;

	// each mask bit drops one byte
	always_comb begin
		o_hit = (i_mask_high || (i_high == i_data[CPU_W-1:BYTE_W]))
			&& (i_mask_low || (i_low == i_data[BYTE_W-1:0]));
	end
endmodule

// [src/bkcq_pkg.sv]
package bkcq_pkg;
	localparam int REG_W    = 8;
	localparam int ADDR_W   = 8;
	localparam int BYTE_W   = 8;
	localparam int XADDR_W  = 6;
	localparam int CPU_W    = 16;
	localparam int MODE_W   = 2;
	localparam int IRQ_W    = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_A_EXT   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_A_HIGH  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_A_LOW   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_B_EXT   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_B_HIGH  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_B_LOW   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_MODE    = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h28;

	// control register fields
	localparam int CTL_A_MASK_HIGH = 7;
	localparam int CTL_A_MASK_LOW  = 6;
	localparam int CTL_B_MASK_HIGH = 5;
	localparam int CTL_B_MASK_LOW  = 4;
	localparam int CTL_A_DIR_EN    = 3;
	localparam int CTL_A_DIR_VAL   = 2;
	localparam int CTL_B_DIR_EN    = 1;
	localparam int CTL_B_DIR_VAL   = 0;

	// mode register fields
	localparam int MODE_LEGACY = 0;
	localparam int MODE_FULL   = 1;

	// interrupt bits
	localparam int IRQ_A = 0;
	localparam int IRQ_B = 1;

	localparam logic [REG_W-1:0]  RST_REG  = 8'h00;
	localparam logic [MODE_W-1:0] RST_MODE = 2'h0;
	localparam logic [IRQ_W-1:0]  RST_IRQ  = 2'h0;
endpackage

// [src/bkcq_qualifier.sv]
`timescale 1ns/100ps
module bkcq_qualifier (
	input  wire logic                              i_sys_clk,
	input  wire logic                              i_reset_n,
	input  wire logic [bkcq_pkg::ADDR_W-1:0]       i_reg_addr,
	input  wire logic [bkcq_pkg::REG_W-1:0]        i_reg_wdata,
	input  wire logic                              i_reg_wr,
	input  wire logic                              i_reg_rd,
	output logic      [bkcq_pkg::REG_W-1:0]        o_reg_rdata,
	input  wire logic                              i_cpu_valid,
	input  wire logic                              i_cpu_rw,
	input  wire logic [bkcq_pkg::CPU_W-1:0]        i_cpu_addr,
	input  wire logic [bkcq_pkg::CPU_W-1:0]        i_cpu_data,
	input  wire logic [bkcq_pkg::XADDR_W-1:0]      i_cpu_xaddr,
	input  wire logic                              i_page_sel,
	output logic                                   o_match_a,
	output logic                                   o_match_b,
	output logic                                   o_irq
);
	import bkcq_pkg::*;

	// core buses share our clock, so no synchroniser
	typedef struct packed {
		logic [REG_W-1:0]  control;
		logic [REG_W-1:0]  a_ext;
		logic [REG_W-1:0]  a_high;
		logic [REG_W-1:0]  a_low;
		logic [REG_W-1:0]  b_ext;
		logic [REG_W-1:0]  b_high;
		logic [REG_W-1:0]  b_low;
		logic [MODE_W-1:0] mode;
		logic [IRQ_W-1:0]  irq_status;
		logic [IRQ_W-1:0]  irq_enable;
		logic              match_a;
		logic              match_b;
		logic              irq;
		logic [REG_W-1:0]  rdata;
	} bkcq_state_t;

	bkcq_state_t st;
	bkcq_state_t next_st;

	logic             hit_a;
	logic             hit_b;
	logic             hit_data;
	logic             legacy;
	logic             full;
	logic             ev_a;
	logic             ev_b;
	logic [IRQ_W-1:0] clr;

	function automatic logic dir_ok(input logic en, input logic val, input logic rw);
		dir_ok = !en || (rw == val);
	endfunction

	function automatic logic [REG_W-1:0] zext_mode(input logic [MODE_W-1:0] v);
		zext_mode = {{(REG_W-MODE_W){1'b0}}, v};
	endfunction

	function automatic logic [REG_W-1:0] zext_irq(input logic [IRQ_W-1:0] v);
		zext_irq = {{(REG_W-IRQ_W){1'b0}}, v};
	endfunction

	assign legacy = st.mode[MODE_LEGACY];
	assign full   = st.mode[MODE_FULL];

	bkcq_addr_cmp u_addr_a (
		.i_mask_high (st.control[CTL_A_MASK_HIGH]),
		.i_mask_low  (st.control[CTL_A_MASK_LOW]),
		.i_ext       (st.a_ext),
		.i_high      (st.a_high),
		.i_low       (st.a_low),
		.i_page_sel  (i_page_sel),
		.i_xaddr     (i_cpu_xaddr),
		.i_addr      (i_cpu_addr),
		.o_hit       (hit_a)
	);

	// second mask field steers comparator B
	bkcq_addr_cmp u_addr_b (
		.i_mask_high (st.control[CTL_B_MASK_HIGH]),
		.i_mask_low  (st.control[CTL_B_MASK_LOW]),
		.i_ext       (st.b_ext),
		.i_high      (st.b_high),
		.i_low       (st.b_low),
		.i_page_sel  (i_page_sel),
		.i_xaddr     (i_cpu_xaddr),
		.i_addr      (i_cpu_addr),
		.o_hit       (hit_b)
	);

	// data compare never sees B extended bits
	bkcq_data_cmp u_data_b (
		.i_mask_high (st.control[CTL_B_MASK_HIGH]),
		.i_mask_low  (st.control[CTL_B_MASK_LOW]),
		.i_high      (st.b_high),
		.i_low       (st.b_low),
		.i_data      (i_cpu_data),
		.o_hit       (hit_data)
	);

	always_comb begin
		next_st = st;
		next_st.rdata = RST_REG;
		clr = RST_IRQ;
		// full mode adds the data qualifier
		// every enabled field in the same cycle
		ev_a = i_cpu_valid && legacy && hit_a
			&& dir_ok(st.control[CTL_A_DIR_EN], st.control[CTL_A_DIR_VAL], i_cpu_rw)
			&& (!full || hit_data);
		// comparator B idle in full mode
		ev_b = i_cpu_valid && legacy && !full && hit_b
			&& dir_ok(st.control[CTL_B_DIR_EN], st.control[CTL_B_DIR_VAL], i_cpu_rw);
		if (i_reg_wr) begin
			case (i_reg_addr)
				OFF_CONTROL: begin
					next_st.control = i_reg_wdata;
				end
				OFF_A_EXT: begin
					next_st.a_ext = i_reg_wdata;
				end
				OFF_A_HIGH: begin
					next_st.a_high = i_reg_wdata;
				end
				OFF_A_LOW: begin
					next_st.a_low = i_reg_wdata;
				end
				OFF_B_EXT: begin
					next_st.b_ext = i_reg_wdata;
				end
				OFF_B_HIGH: begin
					next_st.b_high = i_reg_wdata;
				end
				OFF_B_LOW: begin
					next_st.b_low = i_reg_wdata;
				end
				OFF_MODE: begin
					next_st.mode = i_reg_wdata[MODE_W-1:0];
				end
				OFF_IRQ_EN: begin
					next_st.irq_enable = i_reg_wdata[IRQ_W-1:0];
				end
				OFF_IRQ_CLR: begin
					clr = i_reg_wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (i_reg_rd) begin
			case (i_reg_addr)
				OFF_CONTROL: begin
					next_st.rdata = st.control;
				end
				OFF_A_EXT: begin
					next_st.rdata = st.a_ext;
				end
				OFF_A_HIGH: begin
					next_st.rdata = st.a_high;
				end
				OFF_A_LOW: begin
					next_st.rdata = st.a_low;
				end
				OFF_B_EXT: begin
					next_st.rdata = st.b_ext;
				end
				OFF_B_HIGH: begin
					next_st.rdata = st.b_high;
				end
				OFF_B_LOW: begin
					next_st.rdata = st.b_low;
				end
				OFF_MODE: begin
					next_st.rdata = zext_mode(st.mode);
				end
				OFF_IRQ_ST: begin
					next_st.rdata = zext_irq(st.irq_status);
				end
				OFF_IRQ_EN: begin
					next_st.rdata = zext_irq(st.irq_enable);
				end
				default: begin
					next_st.rdata = RST_REG;
				end
			endcase
		end
		next_st.match_a = ev_a;
		next_st.match_b = ev_b;
		// set beats clear so no event is lost
		next_st.irq_status = (st.irq_status & ~clr) | {ev_b, ev_a};
		next_st.irq = |(next_st.irq_status & next_st.irq_enable);
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_reg_rdata = st.rdata;
	assign o_match_a   = st.match_a;
	assign o_match_b   = st.match_b;
	assign o_irq       = st.irq;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	// helper views for the checks below
	logic a_dir_on;
	logic b_dir_on;
	logic a_mh;
	logic a_ml;
	logic b_mh;
	logic b_ml;
	assign a_dir_on = st.control[CTL_A_DIR_EN];
	assign b_dir_on = st.control[CTL_B_DIR_EN];
	assign a_mh     = st.control[CTL_A_MASK_HIGH];
	assign a_ml     = st.control[CTL_A_MASK_LOW];
	assign b_mh     = st.control[CTL_B_MASK_HIGH];
	assign b_ml     = st.control[CTL_B_MASK_LOW];

	AST_DIR_A: assert property (
		(legacy && a_dir_on && i_cpu_rw != st.control[CTL_A_DIR_VAL]) |=> !o_match_a
	) else $error("comparator A matched the wrong direction");

	AST_DIR_A_OFF: assert property (
		(i_cpu_valid && legacy && !full && !a_dir_on && !a_mh && !a_ml && !i_page_sel
			&& i_cpu_addr == {st.a_high, st.a_low}) |=> o_match_a
	) else $error("comparator A missed with direction disabled");

	AST_DIR_B: assert property (
		(legacy && !full && b_dir_on && i_cpu_rw != st.control[CTL_B_DIR_VAL]) |=> !o_match_b
	) else $error("comparator B matched the wrong direction");

	AST_DIR_B_OFF: assert property (
		(i_cpu_valid && legacy && !full && !b_dir_on && !b_mh && !b_ml && !i_page_sel
			&& i_cpu_addr == {st.b_high, st.b_low}) |=> o_match_b
	) else $error("comparator B missed with direction disabled");

	AST_FULL_B_IDLE: assert property (
		full |=> !o_match_b
	) else $error("comparator B matched in full mode");

	AST_OFF_QUIET: assert property (
		(!legacy || !i_cpu_valid) |=> (!o_match_a && !o_match_b)
	) else $error("match outside a legacy bus cycle");

	AST_PAGED_EXT: assert property (
		(i_page_sel && !(a_mh && a_ml) && i_cpu_xaddr != st.a_ext[XADDR_W-1:0]) |=> !o_match_a
	) else $error("paged compare ignored extended bits");

	AST_UNPAGED_HIGH: assert property (
		(!i_page_sel && !a_ml && i_cpu_addr[CPU_W-1:BYTE_W] != st.a_high) |=> !o_match_a
	) else $error("unpaged compare ignored high byte");

	AST_MASK_10: assert property (
		(b_mh && !b_ml && i_cpu_addr[BYTE_W-1:0] != st.b_low) |=> !o_match_b
	) else $error("mask 1:0 ignored the low byte");

	AST_MASK_11: assert property (
		(i_cpu_valid && legacy && !full && b_mh && b_ml && !b_dir_on && i_page_sel
			&& i_cpu_xaddr == st.b_ext[XADDR_W-1:0]) |=> o_match_b
	) else $error("page-only compare missed");

	AST_MASK_11_NOPAGE: assert property (
		(b_mh && b_ml && !i_page_sel) |=> !o_match_b
	) else $error("page-only compare matched unpaged access");

	AST_MASK_01: assert property (
		(i_cpu_valid && legacy && !full && !b_mh && b_ml && !b_dir_on && !i_page_sel
			&& i_cpu_addr[CPU_W-1:BYTE_W] == st.b_high) |=> o_match_b
	) else $error("256 byte range compare missed");

	AST_FULL_DATA: assert property (
		(full && !b_mh && i_cpu_data[CPU_W-1:BYTE_W] != st.b_high) |=> !o_match_a
	) else $error("full mode ignored the data high byte");

	AST_FULL_NODATA: assert property (
		(i_cpu_valid && legacy && full && b_mh && b_ml && !a_dir_on && !a_mh && !a_ml
			&& !i_page_sel && i_cpu_addr == {st.a_high, st.a_low}) |=> o_match_a
	) else $error("full mode with no data compare missed");

	AST_IRQ_STICKY: assert property (
		o_match_a |-> st.irq_status[IRQ_A]
	) else $error("match did not set its status bit");

	AST_IRQ_LEVEL: assert property (
		o_irq == |(st.irq_status & st.irq_enable)
	) else $error("interrupt output disagrees with status");

	AST_RDATA_ONE: assert property (
		!i_reg_rd |=> o_reg_rdata == RST_REG
	) else $error("read data held beyond one cycle");

	AST_PAGED_HIGH: assert property (
		(i_page_sel && !a_ml && i_cpu_addr[BYTE_W+XADDR_W-1:BYTE_W] != st.a_high[XADDR_W-1:0]) |=> !o_match_a
	) else $error("paged compare ignored high address bits");

	AST_PAGED_LOW: assert property (
		(i_page_sel && !a_ml && i_cpu_addr[BYTE_W-1:0] != st.a_low) |=> !o_match_a
	) else $error("paged compare ignored low byte");

	AST_MASK_10_HIGH: assert property (
		(b_mh && !b_ml && !i_page_sel && i_cpu_addr[CPU_W-1:BYTE_W] != st.b_high) |=> !o_match_b
	) else $error("mask 1:0 ignored the high byte");

	AST_MASK_01_PAGE: assert property (
		(!b_mh && b_ml && i_page_sel && i_cpu_xaddr != st.b_ext[XADDR_W-1:0]) |=> !o_match_b
	) else $error("256 byte range ignored extended bits");

	AST_FULL_DATA_LOW: assert property (
		(full && !b_ml && i_cpu_data[BYTE_W-1:0] != st.b_low) |=> !o_match_a
	) else $error("full mode ignored the data low byte");

	AST_DIR_A_MATCH: assert property (
		(i_cpu_valid && legacy && !full && a_dir_on && i_cpu_rw == st.control[CTL_A_DIR_VAL]
			&& !a_mh && !a_ml && !i_page_sel && i_cpu_addr == {st.a_high, st.a_low}) |=> o_match_a
	) else $error("comparator A missed the selected direction");

	AST_IRQ_STICKY_B: assert property (
		o_match_b |-> st.irq_status[IRQ_B]
	) else $error("match did not set its status bit");

	// status only drops on a clear write
	AST_STATUS_HOLD: assert property (
		(st.irq_status[IRQ_A] && !(i_reg_wr && i_reg_addr == OFF_IRQ_CLR && i_reg_wdata[IRQ_A]))
			|=> st.irq_status[IRQ_A]
	) else $error("status bit dropped without a clear");

	COV_DUAL_A: cover property (legacy && !full ##1 o_match_a);
	COV_DUAL_B: cover property (o_match_b);
	COV_FULL_A: cover property (full ##1 o_match_a);
	COV_IRQ:    cover property (o_irq ##1 !o_irq);
endmodule
